// *** rtl/stt_pkg.sv ***
// constants, register map and state layout of the lane termination trim bank
// assumes one 40 mhz clock, synchronous active-low reset, byte-wide register port
// Overview of operation
// - each lane 1..7 keeps a 4-bit trim
// - trim bit 3 picks raise or lower
// - trim bits 2:0 are the magnitude
// - mode bit clear: checksum sums the fields
// - mode bit set: checksum sums whole octets
package stt_pkg;

    localparam int ADDR_W    = 10;
    localparam int DATA_W    = 8;
    localparam int NL        = 7;   // physical lanes 1..7, index 0 is lane 1
    localparam int TRIM_W    = 4;
    localparam int CODE_W    = 3;
    localparam int N_OCTETS  = 11;  // link configuration octets covered by the checksum
    localparam int N_FIELDS  = 19;

    // documented register offsets
    localparam logic [ADDR_W-1:0] OFS_TRIM [NL] = '{10'h2bc, 10'h2bd, 10'h2be, 10'h2bf,
                                                    10'h2c0, 10'h2c1, 10'h2c2};
    localparam logic [ADDR_W-1:0] OFS_RX_CTRL   = 10'h300;
    // read-only status of the block
    localparam logic [ADDR_W-1:0] OFS_CODE_RB [NL] = '{10'h3e1, 10'h3e2, 10'h3e3, 10'h3e4,
                                                       10'h3e5, 10'h3e6, 10'h3e7};
    localparam logic [ADDR_W-1:0] OFS_CKSUM_RB  = 10'h3f0;

    // field positions
    localparam int TRIM_SIGN_BIT  = 3;
    localparam int TRIM_MAG_MSB   = 2;
    localparam int CKSUM_MODE_BIT = 6;

    // values after reset and code limits
    localparam logic [TRIM_W-1:0] RST_TRIM       = 4'h0;
    localparam logic              RST_CKSUM_MODE = 1'b0;
    localparam logic [CODE_W-1:0] RST_CODE       = 3'h0;
    localparam logic [CODE_W-1:0] CODE_MAX       = 3'h7;
    localparam logic [CODE_W-1:0] CODE_MIN       = 3'h0;

    // parameter field layout inside the configuration octets: octet, lsb, width
    localparam logic [3:0] FLD_OCT [N_FIELDS] = '{4'h0, 4'h1, 4'h1, 4'h2, 4'h2, 4'h2, 4'h3,
                                                  4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h7, 4'h8,
                                                  4'h8, 4'h9, 4'h9, 4'ha, 4'ha};
    localparam logic [2:0] FLD_LSB [N_FIELDS] = '{3'h0, 3'h0, 3'h4, 3'h0, 3'h5, 3'h6, 3'h0,
                                                  3'h7, 3'h0, 3'h0, 3'h0, 3'h0, 3'h6, 3'h0,
                                                  3'h5, 3'h0, 3'h5, 3'h0, 3'h7};
    localparam logic [3:0] FLD_W   [N_FIELDS] = '{4'h8, 4'h4, 4'h4, 4'h5, 4'h1, 4'h1, 4'h5,
                                                  4'h1, 4'h8, 4'h5, 4'h8, 4'h5, 4'h2, 4'h5,
                                                  4'h3, 4'h5, 4'h3, 4'h5, 4'h1};

    // whole state of the register bank
    typedef struct packed {
        logic [NL-1:0][TRIM_W-1:0] trim;
        logic                      cksum_mode;
        logic [NL-1:0][CODE_W-1:0] code;
        logic [DATA_W-1:0]         cksum;
        logic [DATA_W-1:0]         rdata;
    } stt_state_t;

    localparam stt_state_t STT_STATE_RST = '{trim: {NL{RST_TRIM}}, cksum_mode: RST_CKSUM_MODE,
                                             code: {NL{RST_CODE}}, cksum: 8'h00, rdata: 8'h00};

    // trim slot decode: {hit, lane index}
    function automatic logic [3:0] stt_trim_slot(input logic [ADDR_W-1:0] addr);
        logic [3:0] res;
        res = 4'h0;
        for (int l = 0; l < NL; l++) begin
            if (addr == OFS_TRIM[l]) begin
                res = {1'b1, 3'(l)};
            end
        end
        return res;
    endfunction : stt_trim_slot

endpackage : stt_pkg

// *** rtl/stt_lane_if.sv ***
// per-lane carrier between the register bank and the trim adder
// assumes the bank drives trim and calibrated code, the adder returns the applied code
interface stt_lane_if;
    logic [3:0] trim;
    logic [2:0] cal;
    logic [2:0] code;
    modport core (output trim, output cal, input code);
    modport adj  (input trim, input cal, output code);
endinterface : stt_lane_if

// *** rtl/stt_trim_adj.sv ***
// signed-magnitude trim applied to one lane's calibrated termination code
// assumes purely combinational use; the caller registers the result
module stt_trim_adj
    import stt_pkg::*;
(
    stt_lane_if.adj lane
);
    logic [CODE_W:0] sum_w;

    // one spare bit on the sum so an overflow is seen before clamping
    always_comb begin
        sum_w = {1'b0, lane.cal} + {1'b0, lane.trim[TRIM_MAG_MSB:0]};
        if (!lane.trim[TRIM_SIGN_BIT]) begin
            lane.code = (sum_w > {1'b0, CODE_MAX}) ? CODE_MAX : sum_w[CODE_W-1:0];
        end else if (lane.trim[TRIM_MAG_MSB:0] > lane.cal) begin
            lane.code = CODE_MIN;
        end else begin
            lane.code = lane.cal - lane.trim[TRIM_MAG_MSB:0];
        end
    end
endmodule : stt_trim_adj

// *** rtl/stt_cksum.sv ***
// link parameter checksum, by fields or by whole octets
// assumes octets are stable in the clock domain of the caller; result is combinational
module stt_cksum
    import stt_pkg::*;
(
    input  wire logic [N_OCTETS-1:0][7:0] octets_i,
    input  wire logic                     mode_i,
    output logic      [7:0]               sum_o
);
    logic [7:0] oct_sum;
    logic [7:0] fld_sum;
    logic [8:0] mask;

    // both sums wrap modulo 256, as the checksum octet does
    always_comb begin
        oct_sum = 8'h00;
        fld_sum = 8'h00;
        mask    = 9'h000;
        for (int i = 0; i < N_OCTETS; i++) begin
            oct_sum = oct_sum + octets_i[i];
        end
        for (int f = 0; f < N_FIELDS; f++) begin
            mask    = (9'h001 << FLD_W[f]) - 9'h001;
            fld_sum = fld_sum + ((octets_i[FLD_OCT[f]] >> FLD_LSB[f]) & mask[7:0]);
        end
        sum_o = mode_i ? oct_sum : fld_sum;
    end
endmodule : stt_cksum

// *** rtl/stt_regs.sv ***
// termination trim register bank with link checksum mode
// assumes calibrated codes and link octets come from logic on clk_sys_i
//
// Design decision made here: the strobed register port.
module stt_regs
    import stt_pkg::*;
(
    input  wire logic                        clk_sys_i,
    input  wire logic                        rst_n_i,
    input  wire logic [ADDR_W-1:0]           addr_i,
    input  wire logic [DATA_W-1:0]           wdata_i,
    input  wire logic                        wr_i,
    input  wire logic                        rd_i,
    output logic      [DATA_W-1:0]           rdata_o,
    input  wire logic [NL-1:0][CODE_W-1:0]   cal_code_i,
    input  wire logic [N_OCTETS-1:0][7:0]    link_octets_i,
    output logic      [NL-1:0][CODE_W-1:0]   term_code_o,
    output logic      [7:0]                  checksum_o,
    output logic                             checksum_mode_o
);
    stt_state_t                state_q;
    stt_state_t                state_d;
    logic [3:0]                slot;
    logic [DATA_W-1:0]         rd_val;
    logic [NL-1:0][CODE_W-1:0] lane_code;
    logic [7:0]                cksum_w;

    stt_lane_if lane_if [NL] ();

    // one trim adder per lane, fed from the stored trim
    for (genvar g = 0; g < NL; g++) begin : g_lane
        assign lane_if[g].trim = state_q.trim[g];
        assign lane_if[g].cal  = cal_code_i[g];
        assign lane_code[g]    = lane_if[g].code;
        stt_trim_adj u_adj (
            .lane (lane_if[g])
        );
    end

    stt_cksum u_cksum (
        .octets_i (link_octets_i),
        .mode_i   (state_q.cksum_mode),
        .sum_o    (cksum_w)
    );

    // next state: register writes, read mux, registered results
    always_comb begin
        state_d = state_q;
        slot    = stt_trim_slot(addr_i);
        rd_val  = 8'h00;
        if (wr_i) begin
            if (slot[3]) begin
                state_d.trim[slot[2:0]] = wdata_i[TRIM_W-1:0];
            end
            if (addr_i == OFS_RX_CTRL) begin
                state_d.cksum_mode = wdata_i[CKSUM_MODE_BIT];
            end
        end
        // reserved bits and unmapped offsets read as zero
        if (slot[3]) begin
            rd_val = {4'h0, state_q.trim[slot[2:0]]};
        end
        if (addr_i == OFS_RX_CTRL) begin
            rd_val[CKSUM_MODE_BIT] = state_q.cksum_mode;
        end
        for (int l = 0; l < NL; l++) begin
            if (addr_i == OFS_CODE_RB[l]) begin
                rd_val = {5'h00, state_q.code[l]};
            end
        end
        if (addr_i == OFS_CKSUM_RB) begin
            rd_val = state_q.cksum;
        end
        // read data only in the cycle after the strobe, zero otherwise
        state_d.rdata = rd_i ? rd_val : 8'h00;
        state_d.code  = lane_code;
        state_d.cksum = cksum_w;
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_n_i) begin
            state_q <= STT_STATE_RST;
        end else begin
            state_q <= state_d;
        end
    end

    assign rdata_o         = state_q.rdata;
    assign term_code_o     = state_q.code;
    assign checksum_o      = state_q.cksum;
    assign checksum_mode_o = state_q.cksum_mode;

    // assertion helpers: an independent field sum and octet sum
    logic [7:0] ref_fld;
    logic [7:0] ref_oct;
    logic [7:0] o [N_OCTETS];
    always_comb begin
        for (int i = 0; i < N_OCTETS; i++) begin
            o[i] = link_octets_i[i];
        end
        ref_oct = o[0] + o[1] + o[2] + o[3] + o[4] + o[5] + o[6] + o[7] + o[8] + o[9] + o[10];
        ref_fld = o[0] + 8'(o[1][3:0]) + 8'(o[1][7:4]) + 8'(o[2][4:0]) + 8'(o[2][5])
                + 8'(o[2][6]) + 8'(o[3][4:0]) + 8'(o[3][7]) + o[4] + 8'(o[5][4:0]) + o[6]
                + 8'(o[7][4:0]) + 8'(o[7][7:6]) + 8'(o[8][4:0]) + 8'(o[8][7:5])
                + 8'(o[9][4:0]) + 8'(o[9][7:5]) + 8'(o[10][4:0]) + 8'(o[10][7]);
    end

    // mapped offsets, kept apart from the read mux so a decode slip shows up
    logic addr_mapped;
    assign addr_mapped = addr_i inside {[OFS_TRIM[0]:OFS_TRIM[NL-1]], OFS_RX_CTRL,
                                        [OFS_CODE_RB[0]:OFS_CODE_RB[NL-1]], OFS_CKSUM_RB};

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);

    sequence s_trim_wr;
        wr_i && stt_trim_slot(addr_i) >= 4'h8;
    endsequence
    sequence s_same_rd;
        rd_i && !wr_i && addr_i == $past(addr_i);
    endsequence

    trim_store_a: assert property (
        s_trim_wr |=> state_q.trim[$past(slot[2:0])] == $past(wdata_i[TRIM_W-1:0]))
        else $error("trim field did not take written value");

    trim_readback_a: assert property (
        s_trim_wr ##1 s_same_rd |=> rdata_o == {4'h0, $past(wdata_i[3:0], 2)})
        else $error("trim readback differs from written value");

    mode_to_sum_a: assert property (
        wr_i && addr_i == OFS_RX_CTRL && wdata_i[CKSUM_MODE_BIT] ##1 !wr_i [*2]
            |-> checksum_o == $past(ref_oct))
        else $error("checksum not octet sum after mode set");

    unmapped_zero_a: assert property (
        rd_i && !addr_mapped |=> rdata_o == 8'h00)
        else $error("unmapped read not zero");

    // read data is a one-cycle answer, quiet otherwise
    idle_rdata_a: assert property (
        !rd_i |=> rdata_o == 8'h00)
        else $error("read data outside its answer cycle");

    ctrl_readback_a: assert property (
        rd_i && addr_i == OFS_RX_CTRL |=> rdata_o == {1'b0, $past(state_q.cksum_mode), 6'h00})
        else $error("control readback wrong");

    cksum_readback_a: assert property (
        rd_i && addr_i == OFS_CKSUM_RB |=> rdata_o == $past(checksum_o))
        else $error("checksum readback wrong");

    mode_store_a: assert property (
        wr_i && addr_i == OFS_RX_CTRL |=> checksum_mode_o == $past(wdata_i[CKSUM_MODE_BIT]))
        else $error("mode bit did not take written value");

    mode_hold_a: assert property (
        !(wr_i && addr_i == OFS_RX_CTRL) |=> $stable(checksum_mode_o))
        else $error("mode bit moved without a write");

    // readback offsets are read only: a write there leaves every setting alone
    ro_write_a: assert property (
        wr_i && (addr_i == OFS_CKSUM_RB
                 || addr_i inside {[OFS_CODE_RB[0]:OFS_CODE_RB[NL-1]]})
            |=> $stable(state_q.trim) && $stable(state_q.cksum_mode))
        else $error("read-only write changed a setting");

    // synchronous clear: one edge with reset low puts the whole bank back
    reset_clear_a: assert property (@(posedge clk_sys_i) disable iff (1'b0)
        !rst_n_i |=> state_q == STT_STATE_RST)
        else $error("bank not cleared by reset");

    cksum_fields_a: assert property (
        !state_q.cksum_mode |=> checksum_o == $past(ref_fld))
        else $error("field checksum wrong");

    cksum_octets_a: assert property (
        state_q.cksum_mode |=> checksum_o == $past(ref_oct))
        else $error("octet checksum wrong");

    for (genvar g = 0; g < NL; g++) begin : g_chk
        sign_lowers_a: assert property (
            state_q.trim[g][TRIM_SIGN_BIT] |=> term_code_o[g] <= $past(cal_code_i[g]))
            else $error("negative trim raised the code");

        mag_raises_a: assert property (
            !state_q.trim[g][TRIM_SIGN_BIT] |=> term_code_o[g] >= $past(cal_code_i[g])
                && 4'(term_code_o[g]) - 4'($past(cal_code_i[g]))
                   <= 4'($past(state_q.trim[g][TRIM_MAG_MSB:0])))
            else $error("positive trim moved code wrongly");

        zero_neutral_a: assert property (
            state_q.trim[g][TRIM_MAG_MSB:0] == 3'h0 |=> term_code_o[g] == $past(cal_code_i[g]))
            else $error("zero trim changed code");

        clamp_top_a: assert property (
            !state_q.trim[g][TRIM_SIGN_BIT]
                && 4'(cal_code_i[g]) + 4'(state_q.trim[g][TRIM_MAG_MSB:0]) > 4'h7
                |=> term_code_o[g] == CODE_MAX)
            else $error("code not clamped at top");

        clamp_bottom_a: assert property (
            state_q.trim[g][TRIM_SIGN_BIT] && state_q.trim[g][TRIM_MAG_MSB:0] > cal_code_i[g]
                |=> term_code_o[g] == CODE_MIN)
            else $error("code not clamped at bottom");

        // exact amounts inside the legal range
        lower_exact_a: assert property (
            state_q.trim[g][TRIM_SIGN_BIT] && state_q.trim[g][TRIM_MAG_MSB:0] <= cal_code_i[g]
                |=> term_code_o[g] == CODE_W'($past(cal_code_i[g])
                                              - $past(state_q.trim[g][TRIM_MAG_MSB:0])))
            else $error("negative trim removed wrong amount");

        raise_exact_a: assert property (
            !state_q.trim[g][TRIM_SIGN_BIT]
                && 4'(cal_code_i[g]) + 4'(state_q.trim[g][TRIM_MAG_MSB:0]) <= 4'h7
                |=> term_code_o[g] == CODE_W'($past(cal_code_i[g])
                                              + $past(state_q.trim[g][TRIM_MAG_MSB:0])))
            else $error("positive trim added wrong amount");

        trim_hold_a: assert property (
            !(wr_i && addr_i == OFS_TRIM[g]) |=> $stable(state_q.trim[g]))
            else $error("trim moved without a write");

        trim_rd_lane_a: assert property (
            rd_i && addr_i == OFS_TRIM[g] |=> rdata_o == {4'h0, $past(state_q.trim[g])})
            else $error("trim readback not the stored field");

        code_rd_lane_a: assert property (
            rd_i && addr_i == OFS_CODE_RB[g] |=> rdata_o == {5'h00, $past(term_code_o[g])})
            else $error("code readback not the applied code");
    end
endmodule : stt_regs

// *** dv/stt_regs_tb.sv ***
// self-checking bench for the lane termination trim bank
// assumes the bank alone on one 40 mhz clock, register port driven directly by the bench
`define CHK(nm, ex, gt) \
    begin \
        num_checks++; \
        if ((gt) !== (ex)) begin \
            fail_count++; \
            $display("unexpected %s: expected %h, seen %h", nm, ex, gt); \
        end \
    end

module serdes_term_trim_regs_tb;
    import stt_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;

    logic                       clk_sys_i = 1'b0;
    logic                       rst_n_i   = 1'b0;
    logic [ADDR_W-1:0]          addr      = '0;
    logic [DATA_W-1:0]          wdata     = '0;
    logic                       wr        = 1'b0;
    logic                       rd        = 1'b0;
    logic [NL-1:0][CODE_W-1:0]  cal       = '0;
    logic [N_OCTETS-1:0][7:0]   octets    = '0;
    logic [DATA_W-1:0]          rdata_o;
    logic [NL-1:0][CODE_W-1:0]  term_code_o;
    logic [7:0]                 checksum_o;
    logic                       checksum_mode_o;
    int                         fail_count = 0;
    int                         num_checks = 0;
    logic [TRIM_W-1:0]          trims [NL] = '{4'h0, 4'h3, 4'h7, 4'hb, 4'hf, 4'h9, 4'h8};

    // 25 ns period
    always #12.5 clk_sys_i = ~clk_sys_i;

    stt_regs u_stt_regs (
        .clk_sys_i       (clk_sys_i),
        .rst_n_i         (rst_n_i),
        .addr_i          (addr),
        .wdata_i         (wdata),
        .wr_i            (wr),
        .rd_i            (rd),
        .rdata_o         (rdata_o),
        .cal_code_i      (cal),
        .link_octets_i   (octets),
        .term_code_o     (term_code_o),
        .checksum_o      (checksum_o),
        .checksum_mode_o (checksum_mode_o)
    );

    task automatic reg_write(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
        @(posedge clk_sys_i);
        wr    <= 1'b1;
        addr  <= a;
        wdata <= d;
        @(posedge clk_sys_i);
        wr    <= 1'b0;
    endtask : reg_write

    // read data only stands one cycle, so it is taken right after the answering edge
    task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] ex);
        @(posedge clk_sys_i);
        rd   <= 1'b1;
        addr <= a;
        @(posedge clk_sys_i);
        rd   <= 1'b0;
        #1 `CHK("read data", ex, rdata_o)
        @(posedge clk_sys_i);
        #1 `CHK("idle read data", 8'h00, rdata_o)
    endtask : rd_chk

    // signed-magnitude trim, clamped to the code range
    function automatic logic [CODE_W-1:0] exp_code(input int c, input logic [3:0] t);
        int r;
        r = t[TRIM_SIGN_BIT] ? c - int'(t[TRIM_MAG_MSB:0]) : c + int'(t[TRIM_MAG_MSB:0]);
        return (r > 7) ? CODE_MAX : (r < 0) ? CODE_MIN : CODE_W'(r);
    endfunction : exp_code

    task automatic test_reset_values();
        for (int l = 0; l < NL; l++) begin
            rd_chk(OFS_TRIM[l], 8'h00);
        end
        rd_chk(OFS_RX_CTRL, 8'h00);
        rd_chk(10'h123, 8'h00);
    endtask : test_reset_values

    // every lane gets its own trim; reserved upper bits are written high on purpose
    task automatic test_trim_codes();
        @(posedge clk_sys_i);
        for (int l = 0; l < NL; l++) begin
            cal[l] <= CODE_W'(l);
        end
        for (int l = 0; l < NL; l++) begin
            reg_write(OFS_TRIM[l], {4'hf, trims[l]});
        end
        repeat (2) @(posedge clk_sys_i);
        #1;
        for (int l = 0; l < NL; l++) begin
            `CHK("lane code", exp_code(l, trims[l]), term_code_o[l])
            rd_chk(OFS_TRIM[l], {4'h0, trims[l]});
        end
        // calibrated code changes alone must move the applied code too
        @(posedge clk_sys_i);
        for (int l = 0; l < NL; l++) begin
            cal[l] <= CODE_W'(7 - l);
        end
        repeat (2) @(posedge clk_sys_i);
        #1;
        for (int l = 0; l < NL; l++) begin
            `CHK("lane code after cal", exp_code(7 - l, trims[l]), term_code_o[l])
        end
        rd_chk(OFS_CODE_RB[2], {5'h00, exp_code(5, trims[2])});
    endtask : test_trim_codes

    // write then read with no gap, then read then write with no gap
    task automatic test_back_to_back();
        @(posedge clk_sys_i);
        wr    <= 1'b1;
        addr  <= OFS_TRIM[3];
        wdata <= 8'h0d;
        @(posedge clk_sys_i);
        wr    <= 1'b0;
        rd    <= 1'b1;
        @(posedge clk_sys_i);
        rd    <= 1'b0;
        #1 `CHK("read after write", 8'h0d, rdata_o)
        `CHK("lane code negative", exp_code(4, 4'hd), term_code_o[3])
        @(posedge clk_sys_i);
        rd    <= 1'b1;
        @(posedge clk_sys_i);
        rd    <= 1'b0;
        wr    <= 1'b1;
        wdata <= 8'h02;
        #1 `CHK("read before write", 8'h0d, rdata_o)
        @(posedge clk_sys_i);
        wr    <= 1'b0;
        rd_chk(OFS_TRIM[3], 8'h02);
        `CHK("lane code after write", exp_code(4, 4'h2), term_code_o[3])
    endtask : test_back_to_back

    // a second reset in mid-run clears settings and results, then the bank serves again
    task automatic test_mid_reset();
        reg_write(OFS_RX_CTRL, 8'h40);
        @(posedge clk_sys_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clk_sys_i);
        #1 `CHK("code in reset", 21'h0_0000, term_code_o)
        `CHK("checksum in reset", 8'h00, checksum_o)
        `CHK("mode in reset", 1'b0, checksum_mode_o)
        @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        rd_chk(OFS_RX_CTRL, 8'h00);
        rd_chk(OFS_TRIM[3], 8'h00);
        `CHK("code after reset", exp_code(4, 4'h0), term_code_o[3])
    endtask : test_mid_reset

    task automatic test_checksum();
        logic [7:0] fsum;
        logic [7:0] osum;
        fsum = 8'h00;
        osum = 8'h00;
        @(posedge clk_sys_i);
        for (int o = 0; o < N_OCTETS; o++) begin
            octets[o] <= 8'(8'h93 + o * 8'h2d);
            osum = osum + 8'(8'h93 + o * 8'h2d);
        end
        for (int f = 0; f < N_FIELDS; f++) begin
            fsum = fsum + 8'((8'(8'h93 + FLD_OCT[f] * 8'h2d) >> FLD_LSB[f])
                             & ((9'h001 << FLD_W[f]) - 9'h001));
        end
        repeat (2) @(posedge clk_sys_i);
        #1 `CHK("field checksum", fsum, checksum_o)
        reg_write(OFS_RX_CTRL, 8'hff);
        repeat (2) @(posedge clk_sys_i);
        #1 `CHK("octet checksum", osum, checksum_o)
        `CHK("mode bit", 1'b1, checksum_mode_o)
        rd_chk(OFS_RX_CTRL, 8'h40);
        // readback is read only: a write there must not disturb it
        reg_write(OFS_CKSUM_RB, 8'h5a);
        rd_chk(OFS_CKSUM_RB, osum);
        reg_write(OFS_RX_CTRL, 8'h00);
        repeat (2) @(posedge clk_sys_i);
        #1 `CHK("field checksum again", fsum, checksum_o)
    endtask : test_checksum

    task automatic complete_run();
        $display("checks %0d, mismatches %0d", num_checks, fail_count);
        if (fail_count == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : complete_run

    // watchdog: the tests need well under a thousand cycles
    initial begin
        #(5000 * 25);
        fail_count++;
        complete_run();
    end

    initial begin
        repeat (4) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        test_reset_values();
        test_trim_codes();
        test_back_to_back();
        test_checksum();
        test_mid_reset();
        complete_run();
    end

endmodule : serdes_term_trim_regs_tb
